// ---- pkg/via_pkg.sv ----
// constants and types for the vectored interrupt arbiter
// assumes one core clock and a single AHB-Lite master
//
// Contract
// [R1] vector-select start runs arbitration on sources sampled in its first cycle
// [R2] result is an even byte from E0 to FE, one value per rank
// [R3] pending software trap always yields FE, above every other source
// [R4] result replaces the program counter low byte, upper byte kept
// [R5] two-byte vector then read from program memory and loaded into counter
// [R6] nmi pending flag cleared by reset and by the clear-pending instruction
// [R7] external handler clears its own pending bit; hardware leaves it set
// [R8] with nothing active the default entry at E0/E1 is used
// [R9] vector is two bytes, high byte first, giving a 15-bit address
// [R10] rank order: trap FE, reserved FC, CAN rx FA ... port L E2, default E0
// [R11] return-from-irq sets global enable and loads the popped return address
package via_pkg;
   localparam int          RANKS        = 16;
   localparam int          RANK_W       = 4;
   localparam int          PC_W         = 15;
   localparam int          PAGE_MSB     = 14;
   localparam int          PAGE_LSB     = 8;
   localparam int          VEC_HI_MSB   = 6;
   localparam logic [7:0]  VEC_BASE     = 8'hE0;
   localparam logic [7:0]  VEC_TRAP     = 8'hFE;
   localparam logic [7:0]  VEC_DEFAULT  = 8'hE0;
   localparam logic [7:0]  LO_BYTE_SEL  = 8'h01;
   localparam int          TRAP_RANK    = 15;
   // register byte addresses
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_MASK    = 8'h08;
   localparam logic [7:0]  ADDR_INFO    = 8'h0C;
   // field positions
   localparam int          CTRL_GIE     = 0;
   localparam int          EV_VIS_DONE  = 0;
   localparam int          EV_DEFAULT   = 1;
   localparam int          EV_TRAP      = 2;
   localparam int          EV_W         = 3;
   localparam int          INFO_NMI     = 8;
   localparam int          INFO_BUSY    = 9;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY    = 2'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_HI, ST_LO, ST_LOAD} via_state_type;
endpackage

// ---- pkg/via_arb_if.sv ----
// ranking request and result between the top and the priority encoder
// assumes bit 0 of the request is the always-set default rank
`timescale 1ns/10ps
`default_nettype none
interface via_arb_if;
   logic [15:0] active;
   logic [7:0]  offset;
   logic        none;
   modport arb  (input active, output offset, output none);
   modport core (output active, input offset, input none);
endinterface
`default_nettype wire

// ---- hw/via_arb.sv ----
// priority encoder mapping the highest active rank to its vector offset
// assumes combinational use within the core clock cycle
`timescale 1ns/10ps
`default_nettype none
module via_arb
   import via_pkg::*;
(
   via_arb_if.arb a
);
   logic [RANKS:0]      above;
   logic [RANK_W-1:0]   idx [RANKS:0];

   assign above[RANKS] = 1'b0;
   assign idx[RANKS]   = '0;
   // one stage per rank, higher rank masks lower
   for (genvar i = 0; i < RANKS; i++) begin : g_rank
      assign above[i] = above[i+1] | a.active[i];
      assign idx[i]   = (a.active[i] && !above[i+1]) ? RANK_W'(i) : idx[i+1];
   end

   assign a.offset = VEC_BASE + {3'h0, idx[0], 1'b0}; // [R2] [R10]
   assign a.none   = ~|a.active[RANKS-1:1]; // [R8]
endmodule
`default_nettype wire

// ---- hw/via_top.sv ----
// vector-select sequencer with nmi flag, global enable and AHB-Lite registers
// assumes program memory returns data the cycle after a sampled read
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module via_top
   import via_pkg::*;
(
   // clock and reset
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_N_I,
   // ahb-lite slave
   input  wire logic              HSEL_I,
   input  wire logic [31:0]       HADDR_I,
   input  wire logic [1:0]        HTRANS_I,
   input  wire logic              HWRITE_I,
   input  wire logic [2:0]        HSIZE_I,
   input  wire logic [31:0]       HWDATA_I,
   input  wire logic              HREADY_I,
   output logic      [31:0]       HRDATA_O,
   output logic                   HREADYOUT_O,
   output logic      [1:0]        HRESP_O,
   // instruction sequencer
   input  wire logic              VIS_START_I,
   input  wire logic [PC_W-1:0]   PC_I,
   input  wire logic              RETURN_FROM_IRQ_INSTRUCTION_I,
   input  wire logic [PC_W-1:0]   RET_ADDR_I,
   input  wire logic              CLR_NMI_PEND_I,
   input  wire logic              IRQ_ACK_I,
   output logic      [PC_W-1:0]   PC_O,
   output logic                   PC_LOAD_O,
   output logic                   VIS_BUSY_O,
   output logic                   GIE_O,
   output logic                   CORE_INT_REQ_O,
   // program memory
   output logic      [PC_W-1:0]   PMEM_ADDR_O,
   output logic                   PMEM_RD_O,
   input  wire logic [7:0]        PMEM_DATA_I,
   // interrupt sources
   input  wire logic              SW_TRAP_I,
   input  wire logic [14:1]       SRC_ACTIVE_I,
   output logic                   NMI_PEND_O,
   output logic                   IRQ_O
);
   via_arb_if      arb_if ();
   via_state_type  st_q, st_d;
   logic [PC_W-1:0] pc_q, pc_d, addr_q, addr_d, ptr;
   logic            load_q, load_d, rd_q, rd_d;
   logic [7:0]      hi_q, hi_d, off_q, off_d;
   logic            nmi_q, nmi_d, gie_q, gie_d;
   logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic            wr_q, wr_d, hit;
   logic [7:0]      wa_q, wa_d;
   logic [31:0]     rdat_q, rdat_d;

   via_arb u_arb (
      .a (arb_if.arb)
   );

   // trap rank fed from the nmi flag, default rank always set
   assign arb_if.active = {nmi_q, SRC_ACTIVE_I, 1'b1}; // [R1] [R3]
   assign ptr = {PC_I[PAGE_MSB:PAGE_LSB], arb_if.offset}; // [R4]

   // sequencer next state
   always_comb begin
      st_d   = st_q;
      pc_d   = pc_q;
      load_d = 1'b0;
      rd_d   = rd_q;
      addr_d = addr_q;
      hi_d   = hi_q;
      off_d  = off_q;
      case (st_q)
         ST_IDLE: begin
            if (VIS_START_I) begin
               off_d  = arb_if.offset; // [R1]
               pc_d   = ptr; // [R4]
               load_d = 1'b1;
               addr_d = ptr; // [R5]
               rd_d   = 1'b1;
               st_d   = ST_HI;
            end else if (RETURN_FROM_IRQ_INSTRUCTION_I) begin
               pc_d   = RET_ADDR_I; // [R11]
               load_d = 1'b1;
            end
         end
         ST_HI: begin
            addr_d = addr_q | {7'h00, LO_BYTE_SEL}; // [R9]
            st_d   = ST_LO;
         end
         ST_LO: begin
            hi_d = PMEM_DATA_I; // [R9]
            rd_d = 1'b0;
            st_d = ST_LOAD;
         end
         ST_LOAD: begin
            pc_d   = {hi_q[VEC_HI_MSB:0], PMEM_DATA_I}; // [R5] [R9]
            load_d = 1'b1;
            st_d   = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
            rd_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_q   <= ST_IDLE;
         pc_q   <= '0;
         load_q <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= '0;
         hi_q   <= 8'h00;
         off_q  <= VEC_DEFAULT;
      end else begin
         st_q   <= st_d;
         pc_q   <= pc_d;
         load_q <= load_d;
         rd_q   <= rd_d;
         addr_q <= addr_d;
         hi_q   <= hi_d;
         off_q  <= off_d;
      end
   end

   // events
   assign ev[EV_VIS_DONE] = (st_q == ST_LOAD);
   assign ev[EV_DEFAULT]  = (st_q == ST_IDLE) && VIS_START_I && arb_if.none; // [R8]
   assign ev[EV_TRAP]     = SW_TRAP_I;

   // ahb-lite address phase decode
   assign hit = HSEL_I && HTRANS_I[1] && HREADY_I;

   // flags and registers next state
   always_comb begin
      nmi_d  = nmi_q;
      gie_d  = gie_q;
      stat_d = stat_q;
      mask_d = mask_q;
      wr_d   = hit && HWRITE_I;
      wa_d   = hit ? HADDR_I[7:0] : wa_q;
      rdat_d = 32'h0000_0000;
      if (CLR_NMI_PEND_I) begin
         nmi_d = 1'b0; // [R6]
      end
      if (SW_TRAP_I) begin
         nmi_d = 1'b1;
      end
      if (IRQ_ACK_I) begin
         gie_d = 1'b0;
      end
      if (wr_q) begin
         case (wa_q)
            ADDR_CTRL:   gie_d  = HWDATA_I[CTRL_GIE];
            ADDR_STATUS: stat_d = stat_q & ~HWDATA_I[EV_W-1:0];
            ADDR_MASK:   mask_d = HWDATA_I[EV_W-1:0];
            default:     mask_d = mask_q;
         endcase
      end
      if (RETURN_FROM_IRQ_INSTRUCTION_I && st_q == ST_IDLE && !VIS_START_I) begin
         gie_d = 1'b1; // [R11]
      end
      stat_d = stat_d | ev;
      if (hit && !HWRITE_I) begin
         case (HADDR_I[7:0])
            ADDR_CTRL:   rdat_d[CTRL_GIE] = gie_q;
            ADDR_STATUS: rdat_d[EV_W-1:0] = stat_q;
            ADDR_MASK:   rdat_d[EV_W-1:0] = mask_q;
            ADDR_INFO: begin
               rdat_d[7:0]       = off_q;
               rdat_d[INFO_NMI]  = nmi_q;
               rdat_d[INFO_BUSY] = (st_q != ST_IDLE);
            end
            default:     rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         nmi_q  <= 1'b0; // [R6]
         gie_q  <= 1'b0;
         stat_q <= '0;
         mask_q <= MASK_RESET;
         wr_q   <= 1'b0;
         wa_q   <= 8'h00;
         rdat_q <= 32'h0000_0000;
      end else begin
         nmi_q  <= nmi_d;
         gie_q  <= gie_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         wr_q   <= wr_d;
         wa_q   <= wa_d;
         rdat_q <= rdat_d;
      end
   end

   // outputs
   assign HRDATA_O       = rdat_q;
   assign HREADYOUT_O    = 1'b1;
   assign HRESP_O        = HRESP_OKAY;
   assign PC_O           = pc_q;
   assign PC_LOAD_O      = load_q;
   assign VIS_BUSY_O     = (st_q != ST_IDLE);
   assign GIE_O          = gie_q;
   assign CORE_INT_REQ_O = nmi_q | (gie_q & |SRC_ACTIVE_I);
   assign PMEM_ADDR_O    = addr_q;
   assign PMEM_RD_O      = rd_q;
   assign NMI_PEND_O     = nmi_q;
   assign IRQ_O          = |(stat_q & mask_q);

   // checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   sequence vis_go;
      st_q == ST_IDLE && VIS_START_I;
   endsequence

   sequence fetch_walk;
      PMEM_RD_O ##1 PMEM_RD_O ##1 !PMEM_RD_O ##1 PC_LOAD_O;
   endsequence

   sample_first_cycle_a: assert property (vis_go |=> off_q == $past(arb_if.offset)) // [R1]
      else $error("offset not sampled at start");
   even_range_a: assert property (vis_go |-> arb_if.offset[0] == 1'b0 &&
      arb_if.offset >= VEC_BASE && arb_if.offset <= VEC_TRAP) // [R2]
      else $error("offset odd or out of range");
   trap_top_a: assert property (vis_go and nmi_q |=> off_q == VEC_TRAP) // [R3]
      else $error("trap did not give top vector");
   page_kept_a: assert property (vis_go |=> PC_LOAD_O &&
      PC_O == {$past(PC_I[PAGE_MSB:PAGE_LSB]), off_q}) // [R4]
      else $error("pointer not formed from page and offset");
   vector_load_a: assert property (vis_go |=> fetch_walk) // [R5]
      else $error("vector fetch sequence broken");
   nmi_clear_a: assert property (CLR_NMI_PEND_I && !SW_TRAP_I |=> !NMI_PEND_O) // [R6]
      else $error("nmi pending not cleared");
   default_entry_a: assert property (vis_go and arb_if.none and !nmi_q |=>
      off_q == VEC_DEFAULT) // [R8]
      else $error("default vector not used");
   hi_first_a: assert property (st_q == ST_LOAD |=>
      PC_O == {$past(hi_q[VEC_HI_MSB:0]), $past(PMEM_DATA_I)}) // [R9]
      else $error("vector byte order wrong");
   rank_order_a: assert property (vis_go and !nmi_q and SRC_ACTIVE_I[14] |=>
      off_q == VEC_BASE + 8'h1C) // [R10]
      else $error("second rank mis-encoded");
   return_from_irq_instruction_load_a: assert property (st_q == ST_IDLE && RETURN_FROM_IRQ_INSTRUCTION_I && !VIS_START_I |=>
      GIE_O && PC_LOAD_O && PC_O == $past(RET_ADDR_I)) // [R11]
      else $error("return did not restore state");
endmodule
`default_nettype wire

// ---- dv/via_pmem_model.sv ----
// program memory model answering the vector fetch
// assumes reads sampled on the rising core clock edge
`timescale 1ns/10ps
`default_nettype none
module via_pmem_model
   import via_pkg::*;
(
   // core side
   input  wire logic            clk_i,
   input  wire logic [PC_W-1:0] addr_i,
   input  wire logic            rd_i,
   // read data
   output logic      [7:0]      data_o
);
   // table content made from the address; bit 7 of high byte set on purpose
   function automatic logic [7:0] byte_at(input logic [PC_W-1:0] a);
      return a[0] ? (a[7:0] ^ 8'hA5) : (a[7:0] ^ 8'h43);
   endfunction
   initial begin
      data_o = 8'h00;
   end
   // one-cycle latency, released bus shows inverted last value
   always @(posedge clk_i) begin
      data_o <= rd_i ? byte_at(addr_i) : ~data_o;
   end
endmodule
`default_nettype wire

// ---- dv/via_top_tb.sv ----
// self-checking bench for the vector-select block
// assumes the program memory model beside it
`timescale 1ns/10ps
`default_nettype none
module via_top_tb;
   import via_pkg::*;
   logic            clk, rst_n, hsel, hwrite, vector_select_instruction, return_from_irq_instruction, clr_nmi, ack, trap, rd;
   logic [31:0]     haddr, hwdata, hrdata, q;
   logic [1:0]      htrans, hresp;
   logic            hready, pc_load, busy, global_irq_enable, int_req, nmi, irq;
   logic [PC_W-1:0] pc_i, ret_addr, pc_o, paddr;
   logic [14:1]     src;
   logic [14:0]     m;
   logic [7:0]      pdata;
   int              failures = 0;
   int              cmp_count = 0;
   via_top dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .VIS_START_I(vector_select_instruction), .PC_I(pc_i), .RETURN_FROM_IRQ_INSTRUCTION_I(return_from_irq_instruction), .RET_ADDR_I(ret_addr),
      .CLR_NMI_PEND_I(clr_nmi), .IRQ_ACK_I(ack), .PC_O(pc_o), .PC_LOAD_O(pc_load),
      .VIS_BUSY_O(busy), .GIE_O(global_irq_enable), .CORE_INT_REQ_O(int_req), .PMEM_ADDR_O(paddr),
      .PMEM_RD_O(rd), .PMEM_DATA_I(pdata), .SW_TRAP_I(trap), .SRC_ACTIVE_I(src),
      .NMI_PEND_O(nmi), .IRQ_O(irq));
   via_pmem_model pm (.clk_i(clk), .addr_i(paddr), .rd_i(rd), .data_o(pdata));
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // single ahb transfer, entered right after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
      chk(32'(hresp), 32'(HRESP_OKAY));
   endtask
   task automatic vis_run(input logic [14:1] s, input logic [7:0] off);
      logic [PC_W-1:0] ptr;
      logic [7:0]      hi;
      ptr = {7'h01, off};
      hi = pm.byte_at(ptr);
      vector_select_instruction <= 1'b1;
      src <= s;
      pc_i <= 15'h0123;
      @(posedge clk);
      vector_select_instruction <= 1'b0;
      src <= 14'h0000;
      @(negedge clk);
      chk(32'(pc_load), 32'h1);
      chk(32'(pc_o), 32'(ptr));
      chk(32'(paddr), 32'(ptr));
      chk(32'({rd, busy}), 32'h3);
      repeat (3) @(negedge clk);
      chk(32'(pc_load), 32'h1);
      chk(32'(pc_o), 32'({hi[6:0], pm.byte_at(ptr | 15'h1)}));
      chk(32'(busy), 32'h0);
      @(posedge clk);
   endtask
   task automatic t_reset;
      @(negedge clk);
      chk(32'({pc_load, busy, global_irq_enable, nmi, irq, hready}), 32'h1);
      @(posedge clk);
   endtask
   task automatic t_default;
      vis_run(14'h0000, VEC_DEFAULT);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h3);
      ahb(1'b0, ADDR_INFO, 32'h0);
      chk(q, 32'h0E0);
   endtask
   task automatic t_irq;
      ahb(1'b1, ADDR_MASK, 32'h2);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      @(posedge clk);
      ahb(1'b1, ADDR_STATUS, 32'h2);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      @(posedge clk);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h1);
      ahb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_rank;
      for (int k = 1; k <= 14; k++) begin
         m = (15'h1 << (k + 1)) - 15'h2;
         vis_run(m[14:1], VEC_BASE + 8'(2 * k));
      end
   endtask
   task automatic t_trap;
      trap <= 1'b1;
      @(posedge clk);
      trap <= 1'b0;
      @(negedge clk);
      chk(32'({nmi, int_req}), 32'h3);
      @(posedge clk);
      vis_run(14'h3FFF, VEC_TRAP);
      clr_nmi <= 1'b1;
      @(posedge clk);
      clr_nmi <= 1'b0;
      @(negedge clk);
      chk(32'(nmi), 32'h0);
      @(posedge clk);
   endtask
   task automatic t_return_from_irq_instruction;
      return_from_irq_instruction <= 1'b1;
      ret_addr <= 15'h2A5C;
      @(posedge clk);
      return_from_irq_instruction <= 1'b0;
      @(negedge clk);
      chk(32'({pc_load, global_irq_enable, pc_o}), 32'h1AA5C);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(negedge clk);
      chk(32'(global_irq_enable), 32'h0);
      @(posedge clk);
      ahb(1'b1, ADDR_CTRL, 32'h1);
      ahb(1'b0, ADDR_CTRL, 32'h0);
      chk(q, 32'h1);
      src <= 14'h0001;
      @(negedge clk);
      chk(32'(int_req), 32'h1);
      @(posedge clk);
      src <= 14'h0000;
   endtask
   initial begin
      {rst_n, hsel, hwrite, vector_select_instruction, return_from_irq_instruction, clr_nmi, ack, trap} = '0;
      {haddr, hwdata, htrans, pc_i, ret_addr, src} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_default();
      t_irq();
      t_rank();
      t_trap();
      t_return_from_irq_instruction();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
